// ===== hdl/mctr_regs.sv
// Overview of operation
// - Five-bit trim field, zero means nominal
// - Codes 1 to 15 lower clock 2% each
// - Codes 31 down to 16 raise 2% each
// - Bit 6 scales clock by 1.2
// - Bit 4 gates power-down interrupt output
// - Bit 3 gates voltage sign output
// - Bit 2 clear keeps high-pass filter in path
// - Bit 2 set bypasses high-pass filter
// - Bit 1 selects voltage gain one or four
// - Bias field bits 9:8 select bias current
// - Bits 29:28 raise Miller capacitance
// - Receive or software reset restores control-field defaults; check reference, mask and status are kept
// - Control contents feed configuration self-check
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "mctr_defines.svh"
module mctr_regs
  import mctr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic rx_reset,
  input wire logic soft_reset,
  input wire logic [`MCTR_ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic pdn_irq_raw,
  input wire logic volt_sign_raw,
  input wire logic signed [`MCTR_DW-1:0] volt_raw,
  input wire logic signed [`MCTR_DW-1:0] volt_hpf,
  input wire logic signed [`MCTR_DW-1:0] cur_raw,
  input wire logic signed [`MCTR_DW-1:0] cur_hpf,
  output logic powerdown_irq_out,
  output logic volt_sign_out,
  output logic signed [`MCTR_OW-1:0] volt_calc,
  output logic signed [`MCTR_OW-1:0] cur_calc,
  output logic [4:0] osc_freq_trim,
  output logic signed [6:0] osc_trim_pct,
  output logic osc_scale_sixty_hz,
  output logic [3:0] osc_mult_x10,
  output logic powerdown_irq_out_en,
  output logic volt_sign_out_en,
  output logic highpass_bypass,
  output logic volt_digital_gain,
  output logic [1:0] global_bias_adjust,
  output logic [1:0] miller_cap_adjust,
  output logic irq
);

  mctr_state_type state_ff;
  mctr_state_type nxt_state;

  logic cfg_rst;
  logic wr_sys;
  logic wr_bias;
  logic wr_cap;
  logic [31:0] sys_img;
  logic [31:0] bias_img;
  logic [31:0] cap_img;
  logic [31:0] chk_sum;
  logic chk_mism;
  logic rsv_hit;
  logic [`MCTR_IRQ_W-1:0] irq_ev;
  logic [`MCTR_IRQ_W-1:0] irq_clr;
  logic [6:0] trim_code;
  logic [6:0] trim_mag;
  logic signed [`MCTR_OW-1:0] volt_ext;
  logic signed [`MCTR_OW-1:0] cur_ext;

  always_comb begin
    nxt_state = state_ff;
    cfg_rst = rx_reset | soft_reset;
    wr_sys = reg_wr && (reg_addr == `MCTR_OFF_SYSCTL);
    wr_bias = reg_wr && (reg_addr == `MCTR_OFF_BIAS);
    wr_cap = reg_wr && (reg_addr == `MCTR_OFF_ADCCAP);

    // Read images; bits not stored here read as zero
    sys_img = `MCTR_RST_WORD;
    sys_img[`MCTR_TRIM_HI:`MCTR_TRIM_LO] = state_ff.trim;
    sys_img[`MCTR_X12_BIT] = state_ff.x12;
    sys_img[`MCTR_FIX5_BIT] = state_ff.fix5;
    sys_img[`MCTR_PDN_BIT] = state_ff.pdn_en;
    sys_img[`MCTR_SIGN_BIT] = state_ff.sign_en;
    sys_img[`MCTR_BYP_BIT] = state_ff.bypass;
    sys_img[`MCTR_GAIN_BIT] = state_ff.gain;
    bias_img = `MCTR_RST_WORD;
    bias_img[`MCTR_BIAS_HI:`MCTR_BIAS_LO] = state_ff.bias;
    cap_img = `MCTR_RST_WORD;
    cap_img[`MCTR_MCAP_HI:`MCTR_MCAP_LO] = state_ff.mcap;

    // Self-check sum wraps at 32 bits; a mismatch is an event on its rising edge only
    chk_sum = sys_img + bias_img + cap_img;
    chk_mism = (chk_sum != state_ff.chk_ref);
    nxt_state.mism = chk_mism;

    // Flag writes that touch fixed or reserved bits; the value is still stored
    rsv_hit = (wr_sys && ((reg_wdata & `MCTR_SYS_RSV_MASK) != `MCTR_RST_WORD))
      || (wr_bias && ((reg_wdata & `MCTR_BIAS_RSV_MASK) != `MCTR_RST_WORD))
      || (wr_cap && ((reg_wdata & `MCTR_CAP_RSV_MASK) != `MCTR_RST_WORD));

    irq_ev = '0;
    irq_ev[`MCTR_IRQ_CHK] = chk_mism && !state_ff.mism;
    irq_ev[`MCTR_IRQ_RSV] = rsv_hit;

    if (wr_sys) begin
      nxt_state.trim = reg_wdata[`MCTR_TRIM_HI:`MCTR_TRIM_LO];
      nxt_state.x12 = reg_wdata[`MCTR_X12_BIT];
      nxt_state.fix5 = reg_wdata[`MCTR_FIX5_BIT];
      nxt_state.pdn_en = reg_wdata[`MCTR_PDN_BIT];
      nxt_state.sign_en = reg_wdata[`MCTR_SIGN_BIT];
      nxt_state.bypass = reg_wdata[`MCTR_BYP_BIT];
      nxt_state.gain = reg_wdata[`MCTR_GAIN_BIT];
    end
    if (wr_bias) begin
      nxt_state.bias = reg_wdata[`MCTR_BIAS_HI:`MCTR_BIAS_LO];
    end
    if (wr_cap) begin
      nxt_state.mcap = reg_wdata[`MCTR_MCAP_HI:`MCTR_MCAP_LO];
    end
    if (reg_wr && (reg_addr == `MCTR_OFF_CHK_REF)) begin
      nxt_state.chk_ref = reg_wdata;
    end
    if (reg_wr && (reg_addr == `MCTR_OFF_IRQ_MASK)) begin
      nxt_state.mask = reg_wdata[`MCTR_IRQ_W-1:0];
    end

    // Reset of the control fields wins over a write in the same cycle
    if (cfg_rst) begin
      nxt_state.trim = `MCTR_RST_TRIM;
      nxt_state.x12 = 1'b0;
      nxt_state.fix5 = 1'b0;
      nxt_state.pdn_en = 1'b0;
      nxt_state.sign_en = 1'b0;
      nxt_state.bypass = 1'b0;
      nxt_state.gain = 1'b0;
      nxt_state.bias = `MCTR_RST_BIAS;
      nxt_state.mcap = `MCTR_RST_MCAP;
    end

    // Write one to clear; a new event in the same cycle survives
    irq_clr = '0;
    if (reg_wr && (reg_addr == `MCTR_OFF_IRQ_STAT)) begin
      irq_clr = reg_wdata[`MCTR_IRQ_W-1:0];
    end
    nxt_state.stat = (state_ff.stat & ~irq_clr) | irq_ev;

    // Read data stand only in the cycle after the strobe
    nxt_state.rdata = `MCTR_RST_WORD;
    if (reg_rd) begin
      unique case (reg_addr)
        `MCTR_OFF_SYSCTL: nxt_state.rdata = sys_img;
        `MCTR_OFF_BIAS: nxt_state.rdata = bias_img;
        `MCTR_OFF_ADCCAP: nxt_state.rdata = cap_img;
        `MCTR_OFF_IRQ_STAT: nxt_state.rdata[`MCTR_IRQ_W-1:0] = state_ff.stat;
        `MCTR_OFF_IRQ_MASK: nxt_state.rdata[`MCTR_IRQ_W-1:0] = state_ff.mask;
        `MCTR_OFF_CHK_REF: nxt_state.rdata = state_ff.chk_ref;
        `MCTR_OFF_CHK_SUM: nxt_state.rdata = chk_sum;
        default: nxt_state.rdata = `MCTR_RST_WORD;
      endcase
    end

    nxt_state.pdn_out = pdn_irq_raw && state_ff.pdn_en;
    nxt_state.sign_out = volt_sign_raw && state_ff.sign_en;

    // Filter path choice; DC metering needs the raw path
    volt_ext = state_ff.bypass ? `MCTR_OW'(volt_raw) : `MCTR_OW'(volt_hpf);
    cur_ext = state_ff.bypass ? `MCTR_OW'(cur_raw) : `MCTR_OW'(cur_hpf);
    nxt_state.volt = state_ff.gain ? (volt_ext <<< `MCTR_GAIN_SH) : volt_ext;
    nxt_state.cur = cur_ext;

    // Trim decode: upper half counts down from 31 as the first raise step
    trim_code = {2'b00, state_ff.trim};
    if (state_ff.trim[`MCTR_TRIM_UP]) begin
      trim_mag = (`MCTR_TRIM_CODES - trim_code) << `MCTR_TRIM_SH;
    end else begin
      trim_mag = -(trim_code << `MCTR_TRIM_SH);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      // All documented defaults are zero
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign reg_rdata = state_ff.rdata;
  assign osc_freq_trim = state_ff.trim;
  assign osc_trim_pct = $signed(trim_mag);
  assign osc_scale_sixty_hz = state_ff.x12;
  assign osc_mult_x10 = state_ff.x12 ? `MCTR_SCALE_X12 : `MCTR_SCALE_NOM;
  assign powerdown_irq_out_en = state_ff.pdn_en;
  assign volt_sign_out_en = state_ff.sign_en;
  assign highpass_bypass = state_ff.bypass;
  assign volt_digital_gain = state_ff.gain;
  assign global_bias_adjust = state_ff.bias;
  assign miller_cap_adjust = state_ff.mcap;
  assign powerdown_irq_out = state_ff.pdn_out;
  assign volt_sign_out = state_ff.sign_out;
  assign volt_calc = state_ff.volt;
  assign cur_calc = state_ff.cur;
  assign irq = |(state_ff.stat & state_ff.mask);

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sys_wr;
    reg_wr && (reg_addr == `MCTR_OFF_SYSCTL) && !cfg_rst;
  endsequence
  sequence s_sys_rd;
    reg_rd && (reg_addr == `MCTR_OFF_SYSCTL);
  endsequence

  property p_trim_zero;
    (osc_freq_trim == `MCTR_RST_TRIM) |-> (osc_trim_pct == 0);
  endproperty
  a_trim_zero: assert property (p_trim_zero) else $error("trim zero not nominal");

  property p_trim_down;
    !osc_freq_trim[`MCTR_TRIM_UP] |->
      (int'(osc_trim_pct) == -`MCTR_TRIM_STEP_PCT * int'(osc_freq_trim));
  endproperty
  a_trim_down: assert property (p_trim_down) else $error("trim lower step wrong");

  property p_trim_up;
    osc_freq_trim[`MCTR_TRIM_UP] |-> (int'(osc_trim_pct) ==
      `MCTR_TRIM_STEP_PCT * (int'(`MCTR_TRIM_CODES) - int'(osc_freq_trim)));
  endproperty
  a_trim_up: assert property (p_trim_up) else $error("trim raise step wrong");

  property p_scale;
    s_sys_wr |=> (osc_mult_x10 == ($past(reg_wdata[`MCTR_X12_BIT]) ? 4'hC : 4'hA));
  endproperty
  a_scale: assert property (p_scale) else $error("sixty hertz scale wrong");

  property p_pdn_gate;
    !powerdown_irq_out_en |=> !powerdown_irq_out;
  endproperty
  a_pdn_gate: assert property (p_pdn_gate) else $error("power-down output leaks");

  property p_sign_gate;
    volt_sign_out_en && volt_sign_raw |=> volt_sign_out;
  endproperty
  a_sign_gate: assert property (p_sign_gate) else $error("sign output not passed");

  property p_hpf_path;
    !highpass_bypass && !volt_digital_gain |=> (volt_calc == $past(volt_hpf));
  endproperty
  a_hpf_path: assert property (p_hpf_path) else $error("filter path not used");

  property p_byp_path;
    highpass_bypass |=> (cur_calc == $past(cur_raw));
  endproperty
  a_byp_path: assert property (p_byp_path) else $error("bypass path not used");

  property p_sign_off;
    !volt_sign_out_en |=> !volt_sign_out;
  endproperty
  a_sign_off: assert property (p_sign_off) else $error("sign output leaks");

  property p_cur_hpf;
    !highpass_bypass |=> (cur_calc == $past(cur_hpf));
  endproperty
  a_cur_hpf: assert property (p_cur_hpf) else $error("current filter path not used");

  property p_gain4;
    highpass_bypass && volt_digital_gain |=> (volt_calc == $past(volt_raw) * 4);
  endproperty
  a_gain4: assert property (p_gain4) else $error("voltage gain not four");

  property p_bias;
    reg_wr && (reg_addr == `MCTR_OFF_BIAS) && !cfg_rst |=>
      (global_bias_adjust == $past(reg_wdata[`MCTR_BIAS_HI:`MCTR_BIAS_LO]));
  endproperty
  a_bias: assert property (p_bias) else $error("bias field not stored");

  property p_mcap;
    reg_wr && (reg_addr == `MCTR_OFF_ADCCAP) && !cfg_rst |=>
      (miller_cap_adjust == $past(reg_wdata[`MCTR_MCAP_HI:`MCTR_MCAP_LO]));
  endproperty
  a_mcap: assert property (p_mcap) else $error("miller field not stored");

  property p_soft_rst;
    (rx_reset || soft_reset) |=> (sys_img == `MCTR_RST_WORD) && (osc_mult_x10 == 4'hA);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("control not restored");

  property p_chk_irq;
    !state_ff.mism ##1 state_ff.mism |-> state_ff.stat[`MCTR_IRQ_CHK];
  endproperty
  a_chk_irq: assert property (p_chk_irq) else $error("self-check event lost");

  property p_wr_rd;
    s_sys_wr ##1 (s_sys_rd and !cfg_rst) |=>
      (reg_rdata[`MCTR_TRIM_HI:`MCTR_TRIM_LO] == $past(reg_wdata[`MCTR_TRIM_HI:`MCTR_TRIM_LO], 2))
      && (osc_freq_trim == $past(reg_wdata[`MCTR_TRIM_HI:`MCTR_TRIM_LO], 2));
  endproperty
  a_wr_rd: assert property (p_wr_rd) else $error("written trim not effective");

endmodule // mctr_regs
`default_nettype wire

// ===== hdl/mctr_defines.svh
`ifndef MCTR_DEFINES_SVH
`define MCTR_DEFINES_SVH
`define MCTR_ADDR_W 10
`define MCTR_DW 24
`define MCTR_OW 26
`define MCTR_OFF_SYSCTL 10'h180
`define MCTR_OFF_BIAS 10'h182
`define MCTR_OFF_ADCCAP 10'h183
`define MCTR_OFF_IRQ_STAT 10'h184
`define MCTR_OFF_IRQ_MASK 10'h185
`define MCTR_OFF_CHK_REF 10'h186
`define MCTR_OFF_CHK_SUM 10'h187
`define MCTR_TRIM_HI 11
`define MCTR_TRIM_LO 7
`define MCTR_TRIM_UP 4
`define MCTR_X12_BIT 6
`define MCTR_FIX5_BIT 5
`define MCTR_PDN_BIT 4
`define MCTR_SIGN_BIT 3
`define MCTR_BYP_BIT 2
`define MCTR_GAIN_BIT 1
`define MCTR_BIAS_HI 9
`define MCTR_BIAS_LO 8
`define MCTR_MCAP_HI 29
`define MCTR_MCAP_LO 28
`define MCTR_RST_WORD 32'h0000_0000
`define MCTR_RST_TRIM 5'h00
`define MCTR_RST_BIAS 2'h0
`define MCTR_RST_MCAP 2'h0
`define MCTR_SYS_RSV_MASK 32'h0000_0021
`define MCTR_BIAS_RSV_MASK 32'hFFFF_FCFF
`define MCTR_CAP_RSV_MASK 32'hCFFF_FFFF
`define MCTR_TRIM_CODES 7'h20
`define MCTR_TRIM_SH 1
`define MCTR_TRIM_STEP_PCT 2
`define MCTR_SCALE_NOM 4'hA
`define MCTR_SCALE_X12 4'hC
`define MCTR_GAIN_SH 2
`define MCTR_IRQ_W 2
`define MCTR_IRQ_CHK 0
`define MCTR_IRQ_RSV 1
`endif

// ===== hdl/mctr_pkg.sv
`default_nettype none
`include "mctr_defines.svh"
package mctr_pkg;
  typedef struct packed {
    logic [4:0] trim;
    logic x12;
    logic fix5;
    logic pdn_en;
    logic sign_en;
    logic bypass;
    logic gain;
    logic [1:0] bias;
    logic [1:0] mcap;
    logic [31:0] chk_ref;
    logic mism;
    logic [`MCTR_IRQ_W-1:0] stat;
    logic [`MCTR_IRQ_W-1:0] mask;
    logic [31:0] rdata;
    logic pdn_out;
    logic sign_out;
    logic signed [`MCTR_OW-1:0] volt;
    logic signed [`MCTR_OW-1:0] cur;
  } mctr_state_type;
endpackage
`default_nettype wire

// ===== verif/mctr_regs_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module mctr_regs_tb_top;
  logic ref_clk, rst_n, rx_reset, soft_reset, reg_wr, reg_rd, pdn_irq_raw, volt_sign_raw;
  logic [9:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, sysv;
  logic signed [23:0] volt_raw, volt_hpf, cur_raw, cur_hpf;
  logic powerdown_irq_out, volt_sign_out, irq, osc_scale_sixty_hz, powerdown_irq_out_en;
  logic volt_sign_out_en, highpass_bypass, volt_digital_gain;
  logic signed [25:0] volt_calc, cur_calc;
  logic [4:0] osc_freq_trim;
  logic signed [6:0] osc_trim_pct;
  logic [3:0] osc_mult_x10;
  logic [1:0] global_bias_adjust, miller_cap_adjust;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  int bad_count = 0;
  int tests_run = 0;

  mctr_regs i_mctr_regs (.ref_clk, .rst_n, .rx_reset, .soft_reset, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pdn_irq_raw, .volt_sign_raw, .volt_raw, .volt_hpf,
    .cur_raw, .cur_hpf, .powerdown_irq_out, .volt_sign_out, .volt_calc, .cur_calc,
    .osc_freq_trim, .osc_trim_pct, .osc_scale_sixty_hz, .osc_mult_x10, .powerdown_irq_out_en,
    .volt_sign_out_en, .highpass_bypass, .volt_digital_gain, .global_bias_adjust,
    .miller_cap_adjust, .irq);

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task end_of_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Read data stand only in the cycle after the strobe, so look exactly there
  always @(posedge ref_clk) rd_pend <= reg_rd;
  always @(negedge ref_clk) begin
    if (rd_pend === 1'b1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("FAIL %0t read data with nothing expected", $time);
      end else begin
        chk(reg_rdata, exp_q.pop_front());
      end
    end
  end

  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
  endtask

  task rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge ref_clk);
    exp_q.push_back(e);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
  endtask

  task fin;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask

  task wrf(input logic [9:0] a, input logic [31:0] d);
    wr(a, d);
    fin();
  endtask

  function automatic int pct(input logic [4:0] c);
    int ci;
    ci = int'(c);
    if (ci == 0) return 0;
    if (ci < 16) return -2 * ci;
    return 2 * (32 - ci);
  endfunction

  task chk_sys(input logic [31:0] v);
    chk(32'(osc_freq_trim), 32'(v[11:7]));
    chk(32'(osc_trim_pct), 32'(pct(v[11:7])));
    chk(32'(osc_scale_sixty_hz), 32'(v[6]));
    chk(32'(osc_mult_x10), v[6] ? 32'h0000_000C : 32'h0000_000A);
    chk(32'(powerdown_irq_out_en), 32'(v[4]));
    chk(32'(volt_sign_out_en), 32'(v[3]));
    chk(32'(highpass_bypass), 32'(v[2]));
    chk(32'(volt_digital_gain), 32'(v[1]));
  endtask

  task dp;
    logic signed [25:0] ev, ec;
    @(posedge ref_clk);
    volt_raw <= 24'($urandom);
    volt_hpf <= 24'($urandom);
    cur_raw <= 24'($urandom);
    cur_hpf <= 24'($urandom);
    pdn_irq_raw <= 1'($urandom);
    volt_sign_raw <= 1'($urandom);
    @(posedge ref_clk);
    #1;
    ev = sysv[2] ? volt_raw : volt_hpf;
    if (sysv[1]) ev = ev <<< 2;
    ec = sysv[2] ? cur_raw : cur_hpf;
    chk(32'(volt_calc), 32'(ev));
    chk(32'(cur_calc), 32'(ec));
    chk(32'(powerdown_irq_out), 32'(pdn_irq_raw & sysv[4]));
    chk(32'(volt_sign_out), 32'(volt_sign_raw & sysv[3]));
  endtask

  // Irq latency is not pinned down, so allow a short bounded settle
  task wait_irq(input logic e);
    int n;
    n = 0;
    while (irq !== e && n < 8) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    chk(32'(irq), 32'(e));
    if (irq !== e) begin
      end_of_test();
    end
  endtask

  initial begin
    void'($urandom(32'h7D33485F));
    {rst_n, rx_reset, soft_reset, reg_wr, reg_rd, pdn_irq_raw, volt_sign_raw} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    {volt_raw, volt_hpf, cur_raw, cur_hpf} = '0;
    sysv = '0;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk_sys(32'h0);
    rd(10'h180, 32'h0);
    rd(10'h182, 32'h0);
    rd(10'h183, 32'h0);
    rd(10'h1FF, 32'h0);
    fin();
    for (int i = 0; i < 32; i++) begin
      sysv = 32'(i) << 7;
      wrf(10'h180, sysv);
      chk_sys(sysv);
    end
    for (int i = 0; i < 12; i++) begin
      sysv = $urandom & 32'hFFFF_FFDF;
      wr(10'h180, sysv);
      rd(10'h180, sysv & 32'h0000_0FDE);
      sysv = sysv & 32'h0000_0FDE;
      fin();
      chk_sys(sysv);
      repeat (3) dp();
    end
    for (int i = 0; i < 4; i++) begin
      wr(10'h182, 32'(i) << 8);
      wrf(10'h183, 32'(i) << 28);
      chk(32'(global_bias_adjust), 32'(i));
      chk(32'(miller_cap_adjust), 32'(i));
      rd(10'h182, 32'(i) << 8);
      rd(10'h183, 32'(i) << 28);
    end
    wr(10'h184, 32'h3);
    wr(10'h185, 32'h2);
    wrf(10'h182, 32'h0000_0401);
    wait_irq(1'b1);
    rd(10'h184, 32'h2);
    wrf(10'h185, 32'h0);
    wait_irq(1'b0);
    wrf(10'h185, 32'h2);
    wait_irq(1'b1);
    wrf(10'h184, 32'h2);
    wait_irq(1'b0);
    for (int i = 0; i < 2; i++) begin
      wr(10'h180, 32'h0000_0FDE);
      wrf(10'h183, 32'h3000_0000);
      @(posedge ref_clk);
      rx_reset <= (i == 0);
      soft_reset <= (i == 1);
      @(posedge ref_clk);
      rx_reset <= 1'b0;
      soft_reset <= 1'b0;
      #1;
      sysv = 32'h0;
      chk_sys(sysv);
      chk(32'(miller_cap_adjust), 32'h0);
      rd(10'h185, 32'h2);
      fin();
    end
    wr(10'h184, 32'h3);
    wrf(10'h185, 32'h1);
    wrf(10'h180, 32'h0000_0080);
    rd(10'h187, 32'h0000_0080);
    fin();
    wait_irq(1'b1);
    wr(10'h186, 32'h0000_0080);
    wrf(10'h184, 32'h1);
    wait_irq(1'b0);
    wrf(10'h1FF, 32'hFFFF_FFFF);
    rd(10'h1FF, 32'h0);
    rd(10'h180, 32'h0000_0080);
    repeat (3) fin();
    if (exp_q.size() != 0) begin
      bad_count++;
      $display("FAIL %0t reads left unanswered", $time);
    end
    end_of_test();
  end
endmodule // mctr_regs_tb_top
`default_nettype wire
